// ==== src/pcm_dac_serial_input_port.sv ====
// Serial-to-parallel input port of a 16-bit PCM converter
// Notes on behaviour
// - Words are 16 bits sent most significant bit first and are assembled in that order.
// - Serial data is sampled into the shift register on each rising bit clock edge.
// - The least significant bit arrives on the sixteenth pulse, so a word takes sixteen.
// - A low-going load strobe after the sixteen bits copies the shift register onward.
// - Bit clock rates up to 10 MHz are accepted and the sender keeps below that except in t_fast.
// - Words are twos complement with all zeros meaning zero output.
`timescale 1ns/1ps
`include "pcm_serial_defs.svh"
module pcm_dac_serial_input_port #(
  parameter int WORD_BITS = `PCM_WORD_BITS,
  parameter int FIFO_DEPTH = `PCM_FIFO_DEPTH
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_bit_clk,
  input wire logic i_serial_data,
  input wire logic i_word_load_strobe_n,
  input wire logic i_word_ready,
  output logic o_word_valid,
  output logic [WORD_BITS-1:0] o_word,
  output logic signed [WORD_BITS-1:0] o_dac_code,
  output logic o_dac_update,
  output logic o_overrun,
  output logic o_short_word,
  output logic o_clock_too_fast
);
  localparam int HALF_MIN = `PCM_MIN_HALF_CYC;
  // Three-stage pin synchronisers; stage one only feeds stage two
  logic [2:0] clk_sync;
  logic [2:0] dat_sync;
  logic [2:0] stb_sync;
  logic clk_level;
  logic stb_level;
  logic clk_rise;
  logic clk_fall;
  logic stb_fall;
  logic [WORD_BITS-1:0] shift_reg;
  logic [4:0] bit_count;
  logic [7:0] half_cnt;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [WORD_BITS-1:0] fifo_out_data;
  logic load_req;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      clk_sync <= 3'h0;
      dat_sync <= 3'h0;
      stb_sync <= 3'h7;
    end else begin
      clk_sync <= {clk_sync[1:0], i_bit_clk};
      dat_sync <= {dat_sync[1:0], i_serial_data};
      stb_sync <= {stb_sync[1:0], i_word_load_strobe_n};
    end
  end

  // A change counts only once stages two and three agree
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      clk_level <= 1'b0;
      stb_level <= 1'b1;
    end else begin
      if (clk_sync[1] == clk_sync[2]) begin
        clk_level <= clk_sync[2];
      end
      if (stb_sync[1] == stb_sync[2]) begin
        stb_level <= stb_sync[2];
      end
    end
  end

  assign clk_rise = (clk_sync[1] == clk_sync[2]) && clk_sync[2] && !clk_level;
  assign clk_fall = (clk_sync[1] == clk_sync[2]) && !clk_sync[2] && clk_level;
  assign stb_fall = (stb_sync[1] == stb_sync[2]) && !stb_sync[2] && stb_level;

  // Data is taken on the filtered edge; it is stable well before it at 10 MHz
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      shift_reg <= `PCM_WORD_RESET;
    end else if (clk_rise) begin
      shift_reg <= {shift_reg[WORD_BITS-2:0], dat_sync[2]};
    end
  end

  // Counts pulses of the current word; saturates at 31
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      bit_count <= 5'h0;
    end else if (stb_fall) begin
      bit_count <= 5'h0;
    end else if (clk_rise && bit_count != 5'h1F) begin
      bit_count <= bit_count + 5'h1;
    end
  end

  // Half-period monitor for the rate limit
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      half_cnt <= 8'hFF;
      o_clock_too_fast <= 1'b0;
    end else begin
      if (clk_rise || clk_fall) begin
        half_cnt <= 8'h0;
        if (half_cnt < 8'(HALF_MIN - 2)) begin
          o_clock_too_fast <= 1'b1;
        end
      end else if (half_cnt != 8'hFF) begin
        half_cnt <= half_cnt + 8'h1;
      end
    end
  end

  // Strobe copies the shift register; short words still load but are flagged
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_short_word <= 1'b0;
    end else if (stb_fall) begin
      o_short_word <= (bit_count < 5'(WORD_BITS));
    end
  end

  assign load_req = stb_fall;

  // Converter register changes only on a strobe
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_dac_code <= `PCM_WORD_RESET;
      o_dac_update <= 1'b0;
    end else begin
      o_dac_update <= load_req;
      if (load_req) begin
        o_dac_code <= shift_reg;
      end
    end
  end

  // Word stream copy; a full FIFO drops the word and flags it
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_overrun <= 1'b0;
    end else if (load_req && !fifo_in_ready) begin
      o_overrun <= 1'b1;
    end
  end

  pcm_word_fifo #(
    .WIDTH(WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) pcm_word_fifo_inst (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_in_valid(load_req),
    .o_in_ready(fifo_in_ready),
    .i_in_data(shift_reg),
    .o_out_valid(fifo_out_valid),
    // Pop exactly when the output register takes the head, or words repeat
    .i_out_ready(!o_word_valid),
    .o_out_data(fifo_out_data)
  );

  // Output skid register so the port comes straight from flops
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_word_valid <= 1'b0;
      o_word <= `PCM_WORD_RESET;
    end else if (!o_word_valid || i_word_ready) begin
      o_word_valid <= fifo_out_valid && !o_word_valid;
      if (fifo_out_valid && !o_word_valid) begin
        o_word <= fifo_out_data;
      end
    end
  end

  chk_hold_between: assert property (@(posedge i_mclk) disable iff (i_rst)
    !$past(load_req) |-> $stable(o_dac_code))
    else $error("converter code changed without strobe");
  chk_load_copy: assert property (@(posedge i_mclk) disable iff (i_rst)
    load_req |=> (o_dac_code == $past(shift_reg)) && o_dac_update)
    else $error("strobe did not load the shift register");
  chk_msb_first: assert property (@(posedge i_mclk) disable iff (i_rst)
    clk_rise |=> shift_reg[0] == $past(dat_sync[2])
      && shift_reg[WORD_BITS-1:1] == $past(shift_reg[WORD_BITS-2:0]))
    else $error("shift order wrong");
  chk_shift_only_edge: assert property (@(posedge i_mclk) disable iff (i_rst)
    !clk_rise |=> $stable(shift_reg))
    else $error("shift without rising edge");
  chk_count_step: assert property (@(posedge i_mclk) disable iff (i_rst)
    clk_rise && !stb_fall && bit_count < 5'h10 |=> bit_count == $past(bit_count) + 5'h01)
    else $error("bit count did not advance");
  chk_full_word: assert property (@(posedge i_mclk) disable iff (i_rst)
    stb_fall && bit_count == 5'h10 |=> !o_short_word)
    else $error("full word flagged short");
  chk_short_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
    stb_fall && bit_count < 5'(WORD_BITS) |=> o_short_word)
    else $error("short word not flagged");
  chk_count_clear: assert property (@(posedge i_mclk) disable iff (i_rst)
    stb_fall |=> bit_count == 5'h00)
    else $error("bit count not cleared by strobe");
  chk_rate_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_clock_too_fast |=> o_clock_too_fast)
    else $error("rate flag cleared");
  chk_fast_detect: assert property (@(posedge i_mclk) disable iff (i_rst)
    (clk_rise || clk_fall) && half_cnt < 8'(HALF_MIN - 2) |=> o_clock_too_fast)
    else $error("short half period not flagged");
  chk_update_pulse: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_dac_update |=> !o_dac_update)
    else $error("update longer than a cycle");
  chk_update_cause: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_dac_update |-> $past(load_req))
    else $error("update without strobe");
  chk_drop_flag: assert property (@(posedge i_mclk) disable iff (i_rst)
    load_req && !fifo_in_ready |=> o_overrun && $stable(o_overrun) || o_overrun)
    else $error("dropped word not flagged");
  chk_word_hold: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_word_valid && !i_word_ready |=> o_word_valid && $stable(o_word))
    else $error("offered word changed before taken");
endmodule : pcm_dac_serial_input_port

// ==== src/pcm_serial_defs.svh ====
// Constants for the PCM serial input port
`ifndef PCM_SERIAL_DEFS_SVH
`define PCM_SERIAL_DEFS_SVH
`define PCM_WORD_BITS 16
`define PCM_FIFO_DEPTH 4
`define PCM_MCLK_MHZ 100
`define PCM_MAX_BCLK_MHZ 10
`define PCM_MIN_HALF_CYC ((`PCM_MCLK_MHZ + 2 * `PCM_MAX_BCLK_MHZ - 1) / (2 * `PCM_MAX_BCLK_MHZ))
`define PCM_WORD_RESET 16'h0000
`endif

// ==== src/pcm_serial_pkg.sv ====
// Types for the PCM serial input port
package pcm_serial_pkg;
  typedef logic [15:0] pcm_word_t;
endpackage : pcm_serial_pkg

// ==== src/pcm_word_fifo.sv ====
// Small flip-flop FIFO for received words
`timescale 1ns/1ps
module pcm_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data = mem[rd_ptr];
  assign do_wr = i_in_valid && o_in_ready;
  assign do_rd = o_out_valid && i_out_ready;

  always_ff @(posedge i_mclk) begin
    if (do_wr) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule : pcm_word_fifo

// ==== dv/pcm_sender.sv ====
// Behavioural upstream sender driving the serial pins
`timescale 1ns/1ps
module pcm_sender (
  input wire logic i_mclk,
  output logic o_bit_clk,
  output logic o_serial_data,
  output logic o_strobe_n
);
  initial begin
    o_bit_clk = 1'b0;
    o_serial_data = 1'b0;
    o_strobe_n = 1'b1;
  end
  // Half period in mclk; eight gives 80 ns, a 160 ns period, under the rate limit
  int half_cyc = 8;
  task automatic tick(input int n);
    repeat (n) @(posedge i_mclk);
  endtask : tick
  task automatic send(input logic [31:0] bits, input int n, input logic strobe);
    for (int i = n - 1; i >= 0; i--) begin
      o_serial_data <= bits[i];
      tick(half_cyc);
      o_bit_clk <= 1'b1;
      tick(half_cyc);
      o_bit_clk <= 1'b0;
    end
    tick(4);
    // Released data shows the inverse so a stale bit cannot pass
    o_serial_data <= ~o_serial_data;
    if (strobe) begin
      o_strobe_n <= 1'b0;
      tick(4);
      o_strobe_n <= 1'b1;
    end
    tick(16);
  endtask : send
endmodule : pcm_sender

// ==== dv/pcm_dac_serial_input_port_test.sv ====
// Testbench for the PCM serial input port
`timescale 1ns/1ps
module pcm_dac_serial_input_port_test;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic ready = 1'b1;
  logic bclk, sdata, strobe_n, word_valid, dac_update, overrun, short_word, too_fast;
  logic [15:0] word;
  logic signed [15:0] dac_code;
  pcm_serial_pkg::pcm_word_t got_q[$];
  int n_fail = 0;
  int checks_done = 0;
  always #5 mclk = ~mclk;
  pcm_sender pcm_sender_inst (.i_mclk(mclk), .o_bit_clk(bclk), .o_serial_data(sdata),
    .o_strobe_n(strobe_n));
  pcm_dac_serial_input_port pcm_dac_serial_input_port_inst (.i_mclk(mclk), .i_rst(rst),
    .i_bit_clk(bclk), .i_serial_data(sdata), .i_word_load_strobe_n(strobe_n),
    .i_word_ready(ready), .o_word_valid(word_valid), .o_word(word), .o_dac_code(dac_code),
    .o_dac_update(dac_update), .o_overrun(overrun), .o_short_word(short_word),
    .o_clock_too_fast(too_fast));
  int n_upd = 0;
  always @(posedge mclk) begin
    if (word_valid === 1'b1 && ready === 1'b1) got_q.push_back(word);
    if (dac_update === 1'b1) n_upd++;
  end
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t word %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic t_words();
    logic [15:0] w[4] = '{16'h8001, 16'h7ffe, 16'h0000, 16'ha55a};
    got_q.delete();
    n_upd = 0;
    foreach (w[i]) begin
      pcm_sender_inst.send({16'h0000, w[i]}, 16, 1'b1);
      chk16(dac_code, w[i]);
      chk1(short_word, 1'b0);
    end
    chk16(16'(n_upd), 16'h0004);
    chk16(16'(got_q.size()), 16'h0004);
    foreach (w[i]) chk16(got_q[i], w[i]);
    chk1(overrun, 1'b0);
    $display("t_words done");
  endtask : t_words
  task automatic t_hold();
    pcm_sender_inst.send(32'h0000_1234, 16, 1'b0);
    chk16(dac_code, 16'ha55a);
    pcm_sender_inst.send(32'h0000_0000, 0, 1'b1);
    chk16(dac_code, 16'h1234);
    $display("t_hold done");
  endtask : t_hold
  task automatic t_count();
    pcm_sender_inst.send(32'h0000_00ab, 8, 1'b1);
    chk1(short_word, 1'b1);
    pcm_sender_inst.send(32'h0001_c3a5, 17, 1'b1);
    chk1(short_word, 1'b0);
    chk16(dac_code, 16'hc3a5);
    $display("t_count done");
  endtask : t_count
  task automatic t_overrun();
    @(posedge mclk);
    ready <= 1'b0;
    got_q.delete();
    for (int k = 1; k <= 6; k++) pcm_sender_inst.send(32'(16'h1111 * k), 16, 1'b1);
    chk16(dac_code, 16'h6666);
    chk1(overrun, 1'b1);
    @(posedge mclk);
    ready <= 1'b1;
    repeat (30) @(posedge mclk);
    chk16(16'(got_q.size()), 16'h0005);
    chk16(got_q[0], 16'h1111);
    chk16(got_q[4], 16'h5555);
    chk1(too_fast, 1'b0);
    $display("t_overrun done");
  endtask : t_overrun
  // Over-rate bit clock sets the sticky flag; a mid-run reset clears it
  task automatic t_fast();
    pcm_sender_inst.half_cyc = 2;
    pcm_sender_inst.send(32'h0000_0f0f, 16, 1'b1);
    pcm_sender_inst.half_cyc = 8;
    chk1(too_fast, 1'b1);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk1(too_fast, 1'b0);
    chk1(overrun, 1'b0);
    chk16(dac_code, 16'h0000);
    pcm_sender_inst.send(32'h0000_f00d, 16, 1'b1);
    chk16(dac_code, 16'hf00d);
    chk1(short_word, 1'b0);
    chk1(too_fast, 1'b0);
    $display("t_fast done");
  endtask : t_fast
  initial begin
    #300us;
    n_fail++;
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    repeat (4) @(posedge mclk);
    chk16(dac_code, 16'h0000);
    t_words();
    t_hold();
    t_count();
    t_overrun();
    t_fast();
    tally_and_finish();
  end
endmodule : pcm_dac_serial_input_port_test
